// >>> design/gcs_top.v
/*
  Gain calibration and current source register bank with its AHB-Lite slave,
  the offset/gain correction of conversion results and the registered select
  codes for the two excitation current sources.
  Assumes: single AHB-Lite master, whole-word transfers, one clock domain;
  raw conversion results are synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`include "gcs_regs.vh"

module gcs_top #(
    parameter TEN_INPUTS = 1,
    parameter W          = 24
) (
    input  wire         i_clk_sys,
    input  wire         i_arst_n,
    input  wire         i_hsel,
    input  wire [31:0]  i_haddr,
    input  wire [1:0]   i_htrans,
    input  wire         i_hwrite,
    input  wire [2:0]   i_hsize,
    input  wire [31:0]  i_hwdata,
    input  wire         i_hready,
    output reg  [31:0]  o_hrdata,
    output reg          o_hreadyout,
    output reg          o_hresp,
    input  wire [W-1:0] i_raw_data,
    input  wire         i_raw_valid,
    output wire [W-1:0] o_cal_data,
    output wire         o_cal_valid,
    output reg  [10:0]  o_first_pin_sel,
    output reg          o_first_src_on,
    output reg  [11:0]  o_first_src_ua,
    output reg  [10:0]  o_second_pin_sel,
    output reg          o_second_src_on,
    output reg  [11:0]  o_second_src_ua
);
    // address phase capture
    reg         ap_valid_reg;
    reg         ap_write_reg;
    reg         ap_word_reg;
    reg  [7:0]  ap_idx_reg;

    // register file
    reg  [23:0] offset_reg;
    reg  [23:0] gain_reg;
    reg  [7:0]  route_reg;
    reg  [7:0]  level_reg;

    reg  [23:0] offset_next;
    reg  [23:0] gain_next;
    reg  [7:0]  route_next;
    reg  [7:0]  level_next;
    reg  [31:0] rdata_next;

    wire        ap_take;
    wire        dp_write;
    wire [7:0]  rd_idx;

    wire [21:0] dec_pin_sel;
    wire [1:0]  dec_on;
    wire [23:0] dec_ua;
    wire [7:0]  route_fields [0:1];
    wire [7:0]  level_fields [0:1];

    assign ap_take  = i_hsel & i_htrans[`GCS_HTRANS_NONSEQ_BIT] & i_hready;
    assign dp_write = ap_valid_reg & ap_write_reg & ap_word_reg;
    assign rd_idx   = i_haddr[9:2];

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_word_reg  <= 1'b0;
            ap_idx_reg   <= 8'h00;
        end else if (i_hready) begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= i_hwrite;
            ap_word_reg  <= (i_hsize == `GCS_HSIZE_WORD);
            ap_idx_reg   <= i_haddr[9:2];
        end
    end

    // addresses above index 0xFF alias; only bits 9:2 are decoded
    always @* begin
        offset_next = offset_reg;
        gain_next   = gain_reg;
        route_next  = route_reg;
        level_next  = level_reg;
        if (dp_write) begin
            case (ap_idx_reg)
                `GCS_IDX_OFFSET: offset_next = i_hwdata[23:0];
                `GCS_IDX_GAIN:   gain_next   = i_hwdata[23:0];
                `GCS_IDX_ROUTE:  route_next  = i_hwdata[7:0];
                `GCS_IDX_LEVEL:  level_next  = i_hwdata[7:0];
                default:         offset_next = offset_reg;
            endcase
        end
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            offset_reg <= `GCS_OFFSET_RST;
            gain_reg   <= `GCS_GAIN_RST;
            route_reg  <= `GCS_ROUTE_RST;
            level_reg  <= `GCS_LEVEL_RST;
        end else begin
            offset_reg <= offset_next;
            gain_reg   <= gain_next;
            route_reg  <= route_next;
            level_reg  <= level_next;
        end
    end

    // read data comes from the next values, so a read right behind a write
    // to the same register already sees the new word
    always @* begin
        case (rd_idx)
            `GCS_IDX_OFFSET: rdata_next = {8'h00, offset_next};
            `GCS_IDX_GAIN:   rdata_next = {8'h00, gain_next};
            `GCS_IDX_ROUTE:  rdata_next = {24'h000000, route_next};
            `GCS_IDX_LEVEL:  rdata_next = {24'h000000, level_next};
            `GCS_IDX_RESULT: rdata_next = {8'h00, o_cal_data};
            default:         rdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            if (ap_take && !i_hwrite) begin
                o_hrdata <= rdata_next;
            end else begin
                o_hrdata <= 32'h0000_0000;
            end
        end
    end

    // correction pipeline: offset first, then gain
    gcs_corr #(
        .W (W)
    ) u_corr (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_raw_data  (i_raw_data),
        .i_raw_valid (i_raw_valid),
        .i_offset    (offset_reg),
        .i_gain      (gain_reg),
        .o_cal_data  (o_cal_data),
        .o_cal_valid (o_cal_valid)
    );

    // index 0 is the first source (low nibbles), index 1 the second
    assign route_fields[0] = {4'h0, route_reg[`GCS_FIRST_MSB:`GCS_FIRST_LSB]};
    assign route_fields[1] = {4'h0, route_reg[`GCS_SECOND_MSB:`GCS_SECOND_LSB]};
    assign level_fields[0] = {4'h0, level_reg[`GCS_FIRST_MSB:`GCS_FIRST_LSB]};
    assign level_fields[1] = {4'h0, level_reg[`GCS_SECOND_MSB:`GCS_SECOND_LSB]};

    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_src
            gcs_src_dec #(
                .TEN_INPUTS (TEN_INPUTS)
            ) u_dec (
                .i_route   (route_fields[s][3:0]),
                .i_level   (level_fields[s][3:0]),
                .o_pin_sel (dec_pin_sel[s*11 +: 11]),
                .o_on      (dec_on[s]),
                .o_ua      (dec_ua[s*12 +: 12])
            );
        end
    endgenerate

    // source selects are registered so the analog switches see no glitches
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_first_pin_sel  <= 11'h000;
            o_first_src_on   <= 1'b0;
            o_first_src_ua   <= 12'h000;
            o_second_pin_sel <= 11'h000;
            o_second_src_on  <= 1'b0;
            o_second_src_ua  <= 12'h000;
        end else begin
            o_first_pin_sel  <= dec_pin_sel[10:0];
            o_first_src_on   <= dec_on[0];
            o_first_src_ua   <= dec_ua[11:0];
            o_second_pin_sel <= dec_pin_sel[21:11];
            o_second_src_on  <= dec_on[1];
            o_second_src_ua  <= dec_ua[23:12];
        end
    end
endmodule

// >>> design/gcs_regs.vh
/*
  Register indices, field positions, reset values and codes for the gain
  calibration and current source register bank.
  Assumes: included by bare name; registers sit at byte address index * 4.
*/
`ifndef GCS_REGS_VH
`define GCS_REGS_VH

`define GCS_IDX_OFFSET       8'h07
`define GCS_IDX_GAIN         8'h0A
`define GCS_IDX_ROUTE        8'h0D
`define GCS_IDX_LEVEL        8'h0E
`define GCS_IDX_RESULT       8'h13

`define GCS_OFFSET_RST       24'h000000
`define GCS_GAIN_RST         24'h400000
`define GCS_ROUTE_RST        8'hFF
`define GCS_LEVEL_RST        8'h00
`define GCS_GAIN_ONE_SHIFT   22

`define GCS_SECOND_MSB       7
`define GCS_SECOND_LSB       4
`define GCS_FIRST_MSB        3
`define GCS_FIRST_LSB        0

`define GCS_ROUTE_COMMON     4'hA
`define GCS_ROUTE_WIDE_FIRST 4'h5
`define GCS_LEVEL_OFF        4'h0
`define GCS_LEVEL_MAX        4'hA

`define GCS_HTRANS_NONSEQ_BIT 1
`define GCS_HSIZE_WORD       3'h2

`endif

// >>> design/gcs_src_dec.v
/*
  Decoder for one excitation current source: routing code to a one-hot pin
  select and magnitude code to an on flag and a current in microamps.
  Assumes: purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
`include "gcs_regs.vh"

module gcs_src_dec #(
    parameter TEN_INPUTS = 1
) (
    input  wire [3:0]  i_route,
    input  wire [3:0]  i_level,
    output reg  [10:0] o_pin_sel,
    output reg         o_on,
    output reg  [11:0] o_ua
);
    // bit 10 of o_pin_sel is the common input, bits 9..0 the analog inputs
    always @* begin
        o_pin_sel = 11'h000;
        if (i_route == `GCS_ROUTE_COMMON) begin
            o_pin_sel[10] = 1'b1;
        end else if (i_route < `GCS_ROUTE_WIDE_FIRST) begin
            o_pin_sel[i_route] = 1'b1;
        end else if (i_route < `GCS_ROUTE_COMMON && TEN_INPUTS != 0) begin
            o_pin_sel[i_route] = 1'b1;
        end
    end

    always @* begin
        case (i_level)
            4'h1:    o_ua = 12'h032;
            4'h2:    o_ua = 12'h064;
            4'h3:    o_ua = 12'h0FA;
            4'h4:    o_ua = 12'h1F4;
            4'h5:    o_ua = 12'h2EE;
            4'h6:    o_ua = 12'h3E8;
            4'h7:    o_ua = 12'h5DC;
            4'h8:    o_ua = 12'h7D0;
            4'h9:    o_ua = 12'h9C4;
            4'hA:    o_ua = 12'hBB8;
            default: o_ua = 12'h000;
        endcase
        o_on = (i_level != `GCS_LEVEL_OFF) && (i_level <= `GCS_LEVEL_MAX);
    end
endmodule

// >>> design/gcs_corr.v
/*
  Two-stage correction pipeline: offset subtraction, then gain scaling by
  gain / 2^22 with saturation to 24-bit two's complement.
  Assumes: raw results arrive as signed 24-bit words with a valid strobe.
*/
`timescale 1ns/1ps
`include "gcs_regs.vh"

module gcs_corr #(
    parameter W = 24
) (
    input  wire                i_clk_sys,
    input  wire                i_arst_n,
    input  wire [W-1:0]        i_raw_data,
    input  wire                i_raw_valid,
    input  wire [W-1:0]        i_offset,
    input  wire [W-1:0]        i_gain,
    output reg  [W-1:0]        o_cal_data,
    output reg                 o_cal_valid
);
    reg  [W:0]          diff_reg;
    reg                 diff_valid_reg;
    wire signed [2*W+1:0] prod;
    wire signed [2*W+1:0] scaled;
    wire                overflow;

    // 25-bit difference cannot wrap, so extreme offsets stay exact
    assign prod     = $signed(diff_reg) * $signed({1'b0, i_gain});
    assign scaled   = prod >>> `GCS_GAIN_ONE_SHIFT;
    assign overflow = ~((&scaled[2*W+1:W-1]) | ~(|scaled[2*W+1:W-1]));

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            diff_reg       <= {(W+1){1'b0}};
            diff_valid_reg <= 1'b0;
            o_cal_data     <= {W{1'b0}};
            o_cal_valid    <= 1'b0;
        end else begin
            diff_valid_reg <= i_raw_valid;
            if (i_raw_valid) begin
                diff_reg <= {i_raw_data[W-1], i_raw_data} - {i_offset[W-1], i_offset};
            end
            o_cal_valid <= diff_valid_reg;
            if (diff_valid_reg) begin
                if (overflow) begin
                    o_cal_data <= {scaled[2*W+1], {(W-1){~scaled[2*W+1]}}};
                end else begin
                    o_cal_data <= scaled[W-1:0];
                end
            end
        end
    end
endmodule

// >>> tb/gcs_checker.sv
/* Checker for gcs_top: bus answer, source decode and correction timing.
   Assumes: bound to gcs_top; one clock domain. */
`timescale 1ns/1ps
module gcs_checker (
    input logic        i_clk_sys,
    input logic        i_arst_n,
    input logic        i_hsel,
    input logic [1:0]  i_htrans,
    input logic        i_hwrite,
    input logic        i_hready,
    input logic [31:0] o_hrdata,
    input logic        o_hreadyout,
    input logic        o_hresp,
    input logic        i_raw_valid,
    input logic        o_cal_valid,
    input logic [10:0] o_first_pin_sel,
    input logic        o_first_src_on,
    input logic [11:0] o_first_src_ua,
    input logic [10:0] o_second_pin_sel,
    input logic        o_second_src_on,
    input logic [11:0] o_second_src_ua
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    wire rd_req = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
    property p_rdy; o_hreadyout && !o_hresp; endproperty
    a_rdy: assert property (p_rdy) else $error("bus not ready or not okay");
    property p_rd0; !$past(rd_req) |-> o_hrdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside a read");
    property p_on1; o_first_src_on == (o_first_src_ua != 12'h0); endproperty
    a_on1: assert property (p_on1) else $error("first source on flag wrong");
    property p_on2; o_second_src_on == (o_second_src_ua != 12'h0); endproperty
    a_on2: assert property (p_on2) else $error("second source on flag wrong");
    property p_oh1; $onehot0(o_first_pin_sel); endproperty
    a_oh1: assert property (p_oh1) else $error("first source on two pins");
    property p_oh2; $onehot0(o_second_pin_sel); endproperty
    a_oh2: assert property (p_oh2) else $error("second source on two pins");
    property p_lat; i_raw_valid |-> ##2 o_cal_valid; endproperty
    a_lat: assert property (p_lat) else $error("result not two cycles late");
    property p_src; o_cal_valid |-> $past(i_raw_valid, 2); endproperty
    a_src: assert property (p_src) else $error("result without a raw input");
    c_cal: cover property (o_cal_valid);
    c_com: cover property (o_second_pin_sel[10]);
    c_on: cover property (o_first_src_on && o_second_src_on);
endmodule

// >>> tb/tb_top.sv
/* Self-checking bench for gcs_top: AHB-Lite register access, source
   decode and the offset/gain correction path.
   Assumes: design files and checker compiled first. */
`timescale 1ns/1ps
module tb_top;
    logic        i_clk_sys = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0;
    logic [1:0]  i_htrans = 2'h0;
    logic        i_hwrite = 1'b0;
    logic [2:0]  i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0;
    logic [23:0] i_raw_data = 24'h0;
    logic        i_raw_valid = 1'b0;
    wire  [31:0] o_hrdata;
    wire         o_hreadyout, o_hresp, o_cal_valid, o_first_src_on, o_second_src_on;
    wire  [23:0] o_cal_data;
    wire  [10:0] o_first_pin_sel, o_second_pin_sel;
    wire  [11:0] o_first_src_ua, o_second_src_ua;
    wire  [10:0] o_first_pin_sel5, o_second_pin_sel5;
    int          n_fail = 0;
    int          checks = 0;
    logic [31:0] r;
    logic [3:0]  k;
    localparam logic [11:0] UA [0:10] = '{12'h000, 12'h032, 12'h064, 12'h0FA, 12'h1F4,
        12'h2EE, 12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hBB8};
    always #20 i_clk_sys = ~i_clk_sys;
    gcs_top #(.TEN_INPUTS(1), .W(24)) dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_raw_data(i_raw_data),
        .i_raw_valid(i_raw_valid), .o_cal_data(o_cal_data), .o_cal_valid(o_cal_valid),
        .o_first_pin_sel(o_first_pin_sel), .o_first_src_on(o_first_src_on),
        .o_first_src_ua(o_first_src_ua), .o_second_pin_sel(o_second_pin_sel),
        .o_second_src_on(o_second_src_on), .o_second_src_ua(o_second_src_ua));
    // five-input variant shares the bus; only its pin selects are compared
    gcs_top #(.TEN_INPUTS(0), .W(24)) dut5_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(),
        .o_hreadyout(), .o_hresp(), .i_raw_data(i_raw_data), .i_raw_valid(i_raw_valid),
        .o_cal_data(), .o_cal_valid(), .o_first_pin_sel(o_first_pin_sel5),
        .o_first_src_on(), .o_first_src_ua(), .o_second_pin_sel(o_second_pin_sel5),
        .o_second_src_on(), .o_second_src_ua());
    function automatic [10:0] pin_of(input [3:0] c);
        pin_of = (c <= 4'hA) ? (11'h1 << c) : 11'h0;
    endfunction
    function automatic [11:0] ua_of(input [3:0] c);
        ua_of = (c <= 4'hA) ? UA[c] : 12'h000;
    endfunction
    function automatic [10:0] pin5_of(input [3:0] c);
        pin5_of = (c < 4'h5 || c == 4'hA) ? (11'h1 << c) : 11'h0;
    endfunction
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // hready is sampled at each edge; data is taken at the data-phase edge
    task automatic xfer(input [31:0] a, input w, input [31:0] d);
        @(posedge i_clk_sys);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        @(posedge i_clk_sys);
        while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        @(posedge i_clk_sys);
        while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
        r = o_hrdata;
    endtask
    task automatic rd(input [31:0] a, input [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, r);
    endtask
    task automatic settle;
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic conv(input [23:0] raw, input [23:0] e);
        @(posedge i_clk_sys);
        i_raw_data <= raw;
        i_raw_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_raw_valid <= 1'b0;
        settle();
        chk("cal_valid", 32'h1, {31'h0, o_cal_valid});
        chk("cal_data", {8'h0, e}, {8'h0, o_cal_data});
    endtask
    task automatic summarize;
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        rd(32'h34, 32'hFF, "route_rst");
        rd(32'h38, 32'h00, "level_rst");
        rd(32'h28, 32'h400000, "gain_rst");
        rd(32'h1C, 32'h0, "offset_rst");
        chk("pins_rst", 32'h0, {10'h0, o_first_pin_sel, o_second_pin_sel});
        chk("on_rst", 32'h0, {30'h0, o_first_src_on, o_second_src_on});
        conv(24'h123456, 24'h123456);
        for (int c = 0; c < 16; c++) begin
            k = c[3:0];
            xfer(32'h34, 1'b1, {24'h0, k, ~k});
            settle();
            chk("second_pin", {21'h0, pin_of(k)}, {21'h0, o_second_pin_sel});
            chk("first_pin", {21'h0, pin_of(~k)}, {21'h0, o_first_pin_sel});
            chk("second_pin5", {21'h0, pin5_of(k)}, {21'h0, o_second_pin_sel5});
            chk("first_pin5", {21'h0, pin5_of(~k)}, {21'h0, o_first_pin_sel5});
            rd(32'h34, {24'h0, k, ~k}, "route_rd");
            xfer(32'h38, 1'b1, {24'h0, k, ~k});
            settle();
            chk("second_ua", {20'h0, ua_of(k)}, {20'h0, o_second_src_ua});
            chk("first_ua", {20'h0, ua_of(~k)}, {20'h0, o_first_src_ua});
            chk("src_on", {31'h0, ua_of(k) != 12'h0}, {31'h0, o_second_src_on});
            chk("first_on", {31'h0, ua_of(~k) != 12'h0}, {31'h0, o_first_src_on});
            rd(32'h38, {24'h0, k, ~k}, "level_rd");
        end
        xfer(32'h34, 1'b1, 32'hFFFFFF5A);
        rd(32'h34, 32'h5A, "route_upper");
        i_hsize <= 3'h0;
        xfer(32'h34, 1'b1, 32'h33);
        i_hsize <= 3'h2;
        rd(32'h34, 32'h5A, "route_byte");
        xfer(32'h3C, 1'b1, 32'hFFFFFFFF);
        rd(32'h3C, 32'h0, "unmapped");
        xfer(32'h28, 1'b1, 32'hFF800000);
        rd(32'h28, 32'h800000, "gain_rd");
        xfer(32'h1C, 1'b1, 32'h10);
        rd(32'h1C, 32'h10, "offset_rd");
        conv(24'h000100, 24'h0001E0);
        conv(24'hFFFFF0, 24'hFFFFC0);
        conv(24'h7FFFFF, 24'h7FFFFF);
        xfer(32'h28, 1'b1, 32'h200000);
        xfer(32'h1C, 1'b1, 32'h0);
        conv(24'h000003, 24'h000001);
        conv(24'hFFFFFD, 24'hFFFFFE);
        rd(32'h4C, 32'hFFFFFE, "result_rd");
        summarize();
    end
endmodule
bind gcs_top gcs_checker chk_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_hsel(i_hsel),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_raw_valid(i_raw_valid),
    .o_cal_valid(o_cal_valid), .o_first_pin_sel(o_first_pin_sel),
    .o_first_src_on(o_first_src_on), .o_first_src_ua(o_first_src_ua),
    .o_second_pin_sel(o_second_pin_sel), .o_second_src_on(o_second_src_on),
    .o_second_src_ua(o_second_src_ua));
